// ---- bench/ahp_host_model.sv ----
// ahp_host_model: behavioural host processor driving the asynchronous host port
`timescale 1ns/1ps
`default_nettype none
module ahp_host_model (
    input  wire logic              clk_i,     // core clock
    input  wire logic [15:0]       data_i,    // read data from device
    input  wire logic              data_oe_i, // device drive enable
    output var ahp_pkg::ahp_host_s host_o     // host pins
);
    initial
    begin
        host_o = '0;
        host_o.chip_select_n  = 1'b1;
        host_o.write_strobe_n = 1'b1;
        host_o.read_strobe_n  = 1'b1;
        host_o.addr_latch     = 1'b1;
    end

    // one transfer; q and oe taken one edge after start, oe_end one edge after release
    task automatic cycle(input logic es, input logic is_rd, input logic [10:0] a, input logic [15:0] d,
                         output logic [15:0] q, output logic oe, output logic oe_end);
        @(posedge clk_i);
        host_o.host_style_select <= es;
        host_o.chip_select_n     <= 1'b0;
        host_o.addr              <= a;
        host_o.write_strobe_n    <= is_rd;
        host_o.read_strobe_n     <= es ? 1'b0 : ~is_rd;
        host_o.data              <= is_rd ? ~host_o.data : d;
        @(posedge clk_i);
        #1;
        q  = data_i;
        oe = data_oe_i;
        @(posedge clk_i);
        host_o.chip_select_n  <= 1'b1;
        host_o.write_strobe_n <= 1'b1;
        host_o.read_strobe_n  <= 1'b1;
        // released lines must not keep their last value
        host_o.addr           <= ~a;
        host_o.data           <= ~host_o.data;
        @(posedge clk_i);
        #1;
        oe_end = data_oe_i;
    endtask

    // multiplexed bus: address presented on data with a falling latch strobe
    task automatic latch(input logic [10:0] a);
        @(posedge clk_i);
        host_o.addr_latch <= 1'b0;
        host_o.data       <= {5'h00, a};
        @(posedge clk_i);
        host_o.addr_latch <= 1'b1;
        host_o.data       <= ~{5'h00, a};
    endtask
endmodule
`default_nettype wire

// ---- bench/ahp_host_port_tb.sv ----
// ahp_host_port_tb: self-checking testbench of the asynchronous host port
`timescale 1ns/1ps
`default_nettype none
module ahp_host_port_tb;
    logic                clk_i = 1'b0;
    logic                rst_n_i = 1'b0;
    ahp_pkg::ahp_host_s  host;
    ahp_pkg::ahp_stat_s  stat_i = '0;
    logic [1:0]          event_i = 2'h0;
    logic [1:0]          err_inc_i = 2'h0;
    logic [15:0]         data_o;
    logic                data_oe_o;
    logic                irq_o;
    int                  n_mismatch = 0;
    int                  checks = 0;

    always #20 clk_i = ~clk_i;

    ahp_host_model host_m (
        .clk_i     (clk_i),
        .data_i    (data_o),
        .data_oe_i (data_oe_o),
        .host_o    (host)
    );

    ahp_host_port dut (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .host_i    (host),
        .stat_i    (stat_i),
        .event_i   (event_i),
        .err_inc_i (err_inc_i),
        .data_o    (data_o),
        .data_oe_o (data_oe_o),
        .irq_o     (irq_o)
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // read: data must be driven during the cycle and released after it
    task automatic rd(input logic es, input logic [10:0] a, input logic [15:0] exp);
        logic [15:0] q;
        logic        oe;
        logic        oe_end;
        host_m.cycle(es, 1'b1, a, 16'h0000, q, oe, oe_end);
        chk(q, exp);
        chk({15'h0000, oe}, 16'h0001);
        chk({15'h0000, oe_end}, 16'h0000);
    endtask

    task automatic wr(input logic es, input logic [10:0] a, input logic [15:0] d);
        logic [15:0] q;
        logic        oe;
        logic        oe_end;
        host_m.cycle(es, 1'b0, a, d, q, oe, oe_end);
        chk({15'h0000, oe}, 16'h0000);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge clk_i);
        n_mismatch++;
        finish_test();
    end

    initial
    begin
        idle(6);
        chk({14'h0000, data_oe_o, irq_o}, 16'h0000);
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(1'b0, ahp_pkg::ADR_IRQ_EN, 16'h0000);
        rd(1'b0, 11'h7ff, 16'h0000);
        wr(1'b0, ahp_pkg::ADR_IRQ_EN, 16'h007f);
        rd(1'b0, ahp_pkg::ADR_IRQ_EN, 16'h007f);
        wr(1'b1, ahp_pkg::ADR_IRQ_EN, 16'h0055);
        rd(1'b1, ahp_pkg::ADR_IRQ_EN, 16'h0055);
        wr(1'b0, 11'h7ff, 16'hffff);
        wr(1'b1, ahp_pkg::ADR_IRQ_EN, 16'h007f);
        $display("test host styles done");

        @(posedge clk_i);
        stat_i <= 3'h1;
        idle(3);
        chk({15'h0000, irq_o}, 16'h0001);
        rd(1'b0, ahp_pkg::ADR_IRQ, 16'h0001);
        rd(1'b0, ahp_pkg::ADR_STATUS, 16'h0001);
        idle(3);
        rd(1'b0, ahp_pkg::ADR_IRQ, 16'h0000);
        chk({15'h0000, irq_o}, 16'h0000);
        @(posedge clk_i);
        stat_i <= 3'h0;
        idle(3);
        @(posedge clk_i);
        stat_i <= 3'h1;
        idle(3);
        rd(1'b1, ahp_pkg::ADR_IRQ, 16'h0001);
        rd(1'b1, ahp_pkg::ADR_STATUS, 16'h0001);
        @(posedge clk_i);
        stat_i <= 3'h7;
        idle(3);
        rd(1'b0, ahp_pkg::ADR_IRQ, 16'h0006);
        rd(1'b0, ahp_pkg::ADR_STATUS, 16'h0007);
        idle(3);
        rd(1'b0, ahp_pkg::ADR_IRQ, 16'h0000);
        $display("test status interrupts done");

        wr(1'b0, ahp_pkg::ADR_IRQ_EN, 16'h0000);
        @(posedge clk_i);
        stat_i  <= 3'h2;
        event_i <= 2'h3;
        @(posedge clk_i);
        event_i <= 2'h0;
        idle(3);
        chk({15'h0000, irq_o}, 16'h0000);
        rd(1'b0, ahp_pkg::ADR_STATUS, 16'h0002);
        rd(1'b0, ahp_pkg::ADR_IRQ, 16'h0000);
        wr(1'b0, ahp_pkg::ADR_IRQ_EN, 16'h007f);
        @(posedge clk_i);
        event_i <= 2'h3;
        @(posedge clk_i);
        event_i <= 2'h0;
        idle(3);
        chk({15'h0000, irq_o}, 16'h0001);
        rd(1'b0, ahp_pkg::ADR_IRQ, 16'h0018);
        rd(1'b0, ahp_pkg::ADR_IRQ, 16'h0000);
        $display("test event interrupts done");

        @(posedge clk_i);
        err_inc_i <= 2'h3;
        repeat (3) @(posedge clk_i);
        err_inc_i <= 2'h1;
        repeat (2) @(posedge clk_i);
        err_inc_i <= 2'h0;
        wr(1'b0, ahp_pkg::ADR_ACC_CFG, 16'h0001);
        idle(3);
        rd(1'b0, ahp_pkg::ADR_CNT_BASE, 16'h0005);
        rd(1'b0, ahp_pkg::ADR_CNT_BASE + 11'h001, 16'h0000);
        rd(1'b0, ahp_pkg::ADR_CNT_BASE + 11'h002, 16'h0003);
        rd(1'b0, ahp_pkg::ADR_CNT_BASE + 11'h003, 16'h0000);
        rd(1'b0, ahp_pkg::ADR_ACC_CFG, 16'h0000);
        @(posedge clk_i);
        err_inc_i <= 2'h3;
        repeat (2) @(posedge clk_i);
        err_inc_i <= 2'h0;
        wr(1'b0, ahp_pkg::ADR_CNT_BASE + 11'h002, 16'hffff);
        wr(1'b1, ahp_pkg::ADR_CNT_BASE + 11'h001, 16'h0000);
        idle(3);
        rd(1'b0, ahp_pkg::ADR_CNT_BASE, 16'h0007);
        rd(1'b0, ahp_pkg::ADR_CNT_BASE + 11'h002, 16'h0003);
        $display("test counter buffers done");

        // address pins carry garbage from here on; only the latched value may count
        host_m.latch(ahp_pkg::ADR_IRQ_EN);
        wr(1'b0, 11'h7ff, 16'h002a);
        rd(1'b0, 11'h000, 16'h002a);
        $display("test multiplexed address done");
        finish_test();
    end
endmodule
`default_nettype wire

// ---- include/ahp_pkg.sv ----
// ahp_pkg: constants and carrier types of the asynchronous host port block
// What this block does
// - style select low: shared write pin is write strobe, read pin read strobe.
// - strobe style read is read strobe low, write strobe high; device drives data.
// - strobe style write is write strobe low, read strobe high; host drives data.
// - style select high: write pin is read/write level, read pin is enable.
// - enable style: level high means read, low means write.
// - enable style: low enable starts both read and write cycles.
// - multiplexed bus: address taken from data bus at falling latch strobe.
// - one interrupt output gathers all enabled interrupt sources.
// - interrupt bit sets only when its source is active and enabled.
// - status bits and counters update whatever the interrupt enables hold.
// - monitoring sources set their interrupt bit on every status change.
// - reading the status register clears the status change interrupt bits.
// - status keeps tracking live condition; an already set bit stays set.
// - reading the interrupt register clears event and overflow interrupt bits.
// - error counter overflow raises its interrupt bit, subject to enable.
// - writing the snapshot all counters bit buffers every counter together.
// - writing a counter buffer's upper word buffers that counter alone.
// - host reads buffers, waiting three clocks after the buffering write.
package ahp_pkg;
    localparam int ADDR_W   = 11;
    localparam int DATA_W   = 16;
    localparam int NUM_STAT = 3;
    localparam int NUM_EVT  = 2;
    localparam int NUM_CNT  = 2;
    localparam int CNT_W    = 32;
    localparam int IRQ_W    = NUM_STAT + NUM_EVT + NUM_CNT;
    localparam int EVT_LSB  = NUM_STAT;
    localparam int OVF_LSB  = NUM_STAT + NUM_EVT;
    localparam int SNAP_BIT = 0;

    localparam logic [10:0] ADR_ACC_CFG  = 11'h001;
    localparam logic [10:0] ADR_STATUS   = 11'h010;
    localparam logic [10:0] ADR_IRQ      = 11'h011;
    localparam logic [10:0] ADR_IRQ_EN   = 11'h012;
    localparam logic [10:0] ADR_CNT_BASE = 11'h020;

    localparam logic [6:0]  IRQ_EN_RST   = 7'h00;
    localparam logic [2:0]  STAT_RST     = 3'h0;
    localparam logic [15:0] DATA_RST     = 16'h0000;
    localparam logic [10:0] ADDR_RST     = 11'h000;

    typedef struct packed {
        logic        chip_select_n;
        logic        host_style_select;
        logic        write_strobe_n;
        logic        read_strobe_n;
        logic        addr_latch;
        logic [10:0] addr;
        logic [15:0] data;
    } ahp_host_s;

    typedef struct packed {
        logic        signal_loss_state;
        logic        frame_loss_state;
        logic        out_of_frame_state;
    } ahp_stat_s;

    typedef struct packed {
        logic        rd_prev;
        logic        wr_prev;
        logic        ale_prev;
        logic        ale_seen;
        logic [10:0] lat_addr;
        logic [15:0] rdata;
        logic        oe;
        logic [2:0]  stat;
        logic [6:0]  irq_en;
        logic        irq;
    } ahp_top_s;
endpackage

// ---- rtl/ahp_err_counter.sv ----
// ahp_err_counter: wrapping error counter with read buffer and overflow pulse
`timescale 1ns/1ps
`default_nettype none
module ahp_err_counter #(
    parameter int W = 32
) (
    input  wire logic         clk_i,   // core clock
    input  wire logic         rst_n_i, // async reset, active low
    input  wire logic         inc_i,   // one error seen
    input  wire logic         cap_i,   // copy count into buffer
    output logic      [W-1:0] buf_o,   // buffered count
    output logic              ovf_o    // one-cycle overflow pulse
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic [W-1:0] snap;
        logic         ovf;
    } ahp_cnt_s;

    ahp_cnt_s st_ff;
    ahp_cnt_s nxt_st;

    if (W < 2) begin : g_chk
        $error("ahp_err_counter: W must be at least 2");
    end

    always_comb
    begin
        nxt_st     = st_ff;
        nxt_st.ovf = inc_i && (&st_ff.cnt);
        if (inc_i)
            nxt_st.cnt = st_ff.cnt + {{(W-1){1'b0}}, 1'b1};
        if (cap_i)
            nxt_st.snap = st_ff.cnt;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign buf_o = st_ff.snap;
    assign ovf_o = st_ff.ovf;

    property p_capture;
        @(posedge clk_i) disable iff (!rst_n_i)
        cap_i |=> (buf_o == $past(st_ff.cnt)) ##1 (buf_o == $past(buf_o) || $past(cap_i));
    endproperty
    a_capture: assert property (p_capture) else $error("buffer capture wrong");

    property p_count;
        @(posedge clk_i) disable iff (!rst_n_i)
        inc_i |=> (st_ff.cnt == W'($past(st_ff.cnt) + 1)) && (ovf_o == (&$past(st_ff.cnt)));
    endproperty
    a_count: assert property (p_count) else $error("count step wrong");
endmodule
`default_nettype wire

// ---- rtl/ahp_host_port.sv ----
// ahp_host_port: asynchronous host port with interrupts and buffered counters
`timescale 1ns/1ps
`default_nettype none
module ahp_host_port (
    input  wire logic                      clk_i,      // core clock, 25 MHz
    input  wire logic                      rst_n_i,    // async reset, active low
    input  wire ahp_pkg::ahp_host_s        host_i,     // host pins, clock-synchronous
    input  wire ahp_pkg::ahp_stat_s        stat_i,     // live monitoring conditions
    input  wire logic [ahp_pkg::NUM_EVT-1:0] event_i,  // event pulses
    input  wire logic [ahp_pkg::NUM_CNT-1:0] err_inc_i, // error counter increments
    output logic      [15:0]               data_o,     // read data to host
    output logic                           data_oe_o,  // high while driving data
    output logic                           irq_o       // interrupt, active high
);
    localparam int NS = ahp_pkg::NUM_STAT;
    localparam int NE = ahp_pkg::NUM_EVT;
    localparam int NC = ahp_pkg::NUM_CNT;
    localparam int IW = ahp_pkg::IRQ_W;
    localparam int CW = ahp_pkg::CNT_W;

    ahp_pkg::ahp_top_s st_ff;
    ahp_pkg::ahp_top_s nxt_st;

    logic          rd_act;
    logic          wr_act;
    logic          rd_start;
    logic          wr_start;
    logic          ale_fall;
    logic [10:0]   eff_addr;
    logic          snap_all;
    logic [IW-1:0] irq_set;
    logic [IW-1:0] irq_clr;
    logic [IW-1:0] irq_q;
    logic [NC-1:0] cnt_cap;
    logic [NC-1:0] cnt_ovf;
    logic [CW-1:0] cnt_buf [NC];
    logic [2:0]    stat_now;

    if (ahp_pkg::DATA_W != 16 || ahp_pkg::ADDR_W != 11 || CW != 2 * ahp_pkg::DATA_W) begin : g_chk
        $error("ahp_host_port: bus or counter widths unsupported");
    end

    assign stat_now = {stat_i.signal_loss_state,
                       stat_i.frame_loss_state,
                       stat_i.out_of_frame_state};

    // cycle decode for both host styles
    always_comb
    begin
        if (host_i.host_style_select)
        begin
            // enable style: read pin is the enable, write pin the direction
            rd_act = !host_i.chip_select_n && !host_i.read_strobe_n
                     && host_i.write_strobe_n;
            wr_act = !host_i.chip_select_n && !host_i.read_strobe_n
                     && !host_i.write_strobe_n;
        end
        else
        begin
            rd_act = !host_i.chip_select_n && !host_i.read_strobe_n
                     && host_i.write_strobe_n;
            wr_act = !host_i.chip_select_n && !host_i.write_strobe_n
                     && host_i.read_strobe_n;
        end
    end

    assign rd_start = rd_act && !st_ff.rd_prev;
    assign wr_start = wr_act && !st_ff.wr_prev;
    assign ale_fall = st_ff.ale_prev && !host_i.addr_latch;

    // once a latch edge is seen the bus is taken as multiplexed;
    // with the strobe tied high the address pins pass straight through
    always_comb
    begin
        if (ale_fall)
            eff_addr = host_i.data[10:0];
        else if (st_ff.ale_seen)
            eff_addr = st_ff.lat_addr;
        else
            eff_addr = host_i.addr;
    end

    assign snap_all = wr_start && (eff_addr == ahp_pkg::ADR_ACC_CFG)
                      && host_i.data[ahp_pkg::SNAP_BIT];

    // sources are gated by their enable before they reach the sticky bits
    always_comb
    begin
        irq_set = '0;
        irq_set[NS-1:0] = (stat_now ^ st_ff.stat);
        irq_set[ahp_pkg::EVT_LSB +: NE] = event_i;
        irq_set[ahp_pkg::OVF_LSB +: NC] = cnt_ovf;
        irq_set = irq_set & st_ff.irq_en;
        irq_clr = '0;
        if (rd_start && eff_addr == ahp_pkg::ADR_STATUS)
            irq_clr[NS-1:0] = '1;
        if (rd_start && eff_addr == ahp_pkg::ADR_IRQ)
            irq_clr[IW-1:NS] = '1;
    end

    ahp_irq_reg #(
        .W(IW)
    ) u_irq (
        .clk_i  (clk_i),
        .rst_n_i(rst_n_i),
        .set_i  (irq_set),
        .clr_i  (irq_clr),
        .q_o    (irq_q)
    );

    for (genvar i = 0; i < NC; i++) begin : g_cnt
        assign cnt_cap[i] = snap_all || (wr_start
            && eff_addr == ahp_pkg::ADR_CNT_BASE + 11'(2 * i + 1));
        ahp_err_counter #(
            .W(CW)
        ) u_cnt (
            .clk_i  (clk_i),
            .rst_n_i(rst_n_i),
            .inc_i  (err_inc_i[i]),
            .cap_i  (cnt_cap[i]),
            .buf_o  (cnt_buf[i]),
            .ovf_o  (cnt_ovf[i])
        );
    end

    always_comb
    begin
        logic [15:0] rd_val;
        rd_val = '0;
        unique case (eff_addr)
            ahp_pkg::ADR_STATUS: rd_val = {13'h0000, st_ff.stat};
            ahp_pkg::ADR_IRQ:    rd_val = {9'h000, irq_q};
            ahp_pkg::ADR_IRQ_EN: rd_val = {9'h000, st_ff.irq_en};
            default:             rd_val = '0;
        endcase
        for (int k = 0; k < NC; k++)
        begin
            if (eff_addr == ahp_pkg::ADR_CNT_BASE + 11'(2 * k))
                rd_val = cnt_buf[k][15:0];
            if (eff_addr == ahp_pkg::ADR_CNT_BASE + 11'(2 * k + 1))
                rd_val = cnt_buf[k][31:16];
        end

        nxt_st          = st_ff;
        nxt_st.rd_prev  = rd_act;
        nxt_st.wr_prev  = wr_act;
        nxt_st.ale_prev = host_i.addr_latch;
        if (ale_fall)
        begin
            nxt_st.ale_seen = 1'b1;
            nxt_st.lat_addr = host_i.data[10:0];
        end
        nxt_st.stat = stat_now;
        // data held for the whole read so a slow host sees it settled
        if (rd_start)
            nxt_st.rdata = rd_val;
        nxt_st.oe = rd_act;
        if (wr_start && eff_addr == ahp_pkg::ADR_IRQ_EN)
            nxt_st.irq_en = host_i.data[IW-1:0];
        nxt_st.irq = |(irq_q & st_ff.irq_en);
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_ff          <= '0;
            st_ff.ale_prev <= 1'b1;
            st_ff.lat_addr <= ahp_pkg::ADDR_RST;
            st_ff.rdata    <= ahp_pkg::DATA_RST;
            st_ff.stat     <= ahp_pkg::STAT_RST;
            st_ff.irq_en   <= ahp_pkg::IRQ_EN_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign data_o    = st_ff.rdata;
    assign data_oe_o = st_ff.oe;
    assign irq_o     = st_ff.irq;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_strobe_read;
        !host_i.chip_select_n && !host_i.host_style_select
        && !host_i.read_strobe_n && host_i.write_strobe_n;
    endsequence

    sequence s_enable_read;
        !host_i.chip_select_n && host_i.host_style_select
        && !host_i.read_strobe_n && host_i.write_strobe_n;
    endsequence

    sequence s_enable_write;
        !host_i.chip_select_n && host_i.host_style_select
        && !host_i.read_strobe_n && !host_i.write_strobe_n;
    endsequence

    property p_strobe_read;
        s_strobe_read |=> data_oe_o;
    endproperty
    a_strobe_read: assert property (p_strobe_read) else $error("strobe read not driven");

    property p_enable_read;
        s_enable_read ##1 s_enable_read |=> data_oe_o && $stable(data_o);
    endproperty
    a_enable_read: assert property (p_enable_read) else $error("enable read not driven");

    property p_enable_write;
        s_enable_write |=> !data_oe_o;
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("drove bus in write");

    property p_release;
        host_i.chip_select_n |=> !data_oe_o;
    endproperty
    a_release: assert property (p_release) else $error("bus driven unselected");

    property p_ale_latch;
        ale_fall |=> st_ff.ale_seen && (st_ff.lat_addr == $past(host_i.data[10:0]));
    endproperty
    a_ale_latch: assert property (p_ale_latch) else $error("address not latched");

    property p_stat_change;
        ((stat_now != st_ff.stat) && ((stat_now ^ st_ff.stat) & st_ff.irq_en[NS-1:0]) != 3'h0)
        |=> (irq_q[NS-1:0] & $past((stat_now ^ st_ff.stat) & st_ff.irq_en[NS-1:0]))
            == $past((stat_now ^ st_ff.stat) & st_ff.irq_en[NS-1:0]);
    endproperty
    a_stat_change: assert property (p_stat_change) else $error("status change missed");

    property p_stat_clear;
        (rd_start && eff_addr == ahp_pkg::ADR_STATUS && stat_now == st_ff.stat)
        |=> irq_q[NS-1:0] == 3'h0;
    endproperty
    a_stat_clear: assert property (p_stat_clear) else $error("status read kept irq");

    property p_irq_clear;
        (rd_start && eff_addr == ahp_pkg::ADR_IRQ && irq_set[IW-1:NS] == '0)
        |=> irq_q[IW-1:NS] == '0 && ($stable(irq_q[NS-1:0]) || $past(irq_set[NS-1:0]) != '0);
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq read kept bits");

    property p_irq_out;
        ((irq_q & st_ff.irq_en) != '0) |=> irq_o;
    endproperty
    a_irq_out: assert property (p_irq_out) else $error("irq output missing");

    property p_irq_quiet;
        (st_ff.irq_en == '0) ##1 (st_ff.irq_en == '0) |-> !irq_o;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq while masked");

    sequence s_strobe_write;
        !host_i.chip_select_n && !host_i.host_style_select
        && !host_i.write_strobe_n && host_i.read_strobe_n;
    endsequence

    property p_strobe_write;
        s_strobe_write |=> !data_oe_o;
    endproperty
    a_strobe_write: assert property (p_strobe_write) else $error("drove bus in strobe write");

    property p_dir_excl;
        rd_act |-> !wr_act;
    endproperty
    a_dir_excl: assert property (p_dir_excl) else $error("read and write decoded together");

    // read data moves only at a read start, so a slow host sees one value
    property p_read_hold;
        !rd_start |=> $stable(data_o);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("read data moved");

    property p_read_en;
        rd_start && eff_addr == ahp_pkg::ADR_IRQ_EN |=> data_o == {9'h000, $past(st_ff.irq_en)};
    endproperty
    a_read_en: assert property (p_read_en) else $error("enable readback wrong");

    property p_read_stat;
        rd_start && eff_addr == ahp_pkg::ADR_STATUS |=> data_o == {13'h0000, $past(st_ff.stat)};
    endproperty
    a_read_stat: assert property (p_read_stat) else $error("status readback wrong");

    property p_en_write;
        wr_start && eff_addr == ahp_pkg::ADR_IRQ_EN |=> st_ff.irq_en == $past(host_i.data[IW-1:0]);
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable write lost");

    property p_en_hold;
        !(wr_start && eff_addr == ahp_pkg::ADR_IRQ_EN) |=> $stable(st_ff.irq_en);
    endproperty
    a_en_hold: assert property (p_en_hold) else $error("enable changed unwritten");

    property p_stat_track;
        stat_now != st_ff.stat |=> st_ff.stat == $past(stat_now);
    endproperty
    a_stat_track: assert property (p_stat_track) else $error("status copy stale");

    // a masked source may never set its bit, not only stay off the pin
    property p_masked;
        1'b1 |=> (irq_q & ~$past(irq_q) & ~$past(st_ff.irq_en)) == '0;
    endproperty
    a_masked: assert property (p_masked) else $error("masked source set its bit");

    property p_event_set;
        (event_i & st_ff.irq_en[ahp_pkg::EVT_LSB +: NE]) != '0 |=> irq_q[ahp_pkg::EVT_LSB +: NE] != '0;
    endproperty
    a_event_set: assert property (p_event_set) else $error("event irq missed");

    property p_snap_all;
        snap_all |-> cnt_cap == '1;
    endproperty
    a_snap_all: assert property (p_snap_all) else $error("group capture missed a counter");

    property p_cap_high;
        wr_start && eff_addr == ahp_pkg::ADR_CNT_BASE + 11'h001 |-> cnt_cap[0] && !cnt_cap[NC-1];
    endproperty
    a_cap_high: assert property (p_cap_high) else $error("upper word write missed");

    property p_cap_low;
        wr_start && eff_addr == ahp_pkg::ADR_CNT_BASE |-> cnt_cap == '0;
    endproperty
    a_cap_low: assert property (p_cap_low) else $error("lower word write buffered");

    // the enable follows the decode alone, so a dropped strobe frees the bus
    property p_oe_drop;
        !rd_act |=> !data_oe_o;
    endproperty
    a_oe_drop: assert property (p_oe_drop) else $error("bus held after read");

    property p_irq_drop;
        (irq_q & st_ff.irq_en) == '0 |=> !irq_o;
    endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("irq output stuck");

    property p_pass_addr;
        !st_ff.ale_seen && !ale_fall |-> eff_addr == host_i.addr;
    endproperty
    a_pass_addr: assert property (p_pass_addr) else $error("address pins not used");

    property p_mux_stays;
        st_ff.ale_seen && !ale_fall |=> st_ff.ale_seen && $stable(st_ff.lat_addr);
    endproperty
    a_mux_stays: assert property (p_mux_stays) else $error("latched address lost");
endmodule
`default_nettype wire

// ---- rtl/ahp_irq_reg.sv ----
// ahp_irq_reg: sticky interrupt bits, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module ahp_irq_reg #(
    parameter int W = 7
) (
    input  wire logic         clk_i,   // core clock
    input  wire logic         rst_n_i, // async reset, active low
    input  wire logic [W-1:0] set_i,   // enabled source hits
    input  wire logic [W-1:0] clr_i,   // clear-on-read pulses
    output logic      [W-1:0] q_o      // sticky bits
);
    typedef struct packed {
        logic [W-1:0] bits;
    } ahp_irqr_s;

    ahp_irqr_s st_ff;
    ahp_irqr_s nxt_st;

    if (W < 1) begin : g_chk
        $error("ahp_irq_reg: W must be at least 1");
    end

    always_comb
    begin
        nxt_st      = st_ff;
        // an event in the clearing cycle survives
        nxt_st.bits = (st_ff.bits & ~clr_i) | set_i;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign q_o = st_ff.bits;

    property p_set_wins;
        @(posedge clk_i) disable iff (!rst_n_i)
        (set_i != '0) |=> ((q_o & $past(set_i)) == $past(set_i));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("irq set lost");
endmodule
`default_nettype wire
